// ===== verilog/pic_regs.vh
// Register map, field positions and reset values of the interrupt controller.
// Assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus.
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// Register indices (byte address is four times these)
`define PIC_IDX_WEDGE 16'hff90
`define PIC_IDX_PEDGE 16'hfff2
`define PIC_IDX_EN1 16'hfff3
`define PIC_IDX_EN2 16'hfff4
`define PIC_IDX_RF1 16'hfff6
`define PIC_IDX_RF2 16'hfff7
`define PIC_IDX_WRF 16'hfff9

// Reset values
`define PIC_RST_WEDGE 8'h00
`define PIC_RST_PEDGE 8'he0
`define PIC_RST_EN 8'h00
`define PIC_RST_RF1 8'h20
`define PIC_RST_RF2 8'h00
`define PIC_RST_WRF 8'h00

// Fixed bits of the edge select register
`define PIC_PEDGE_FIXED 8'he0
`define PIC_PEDGE_RW 8'h1f

// First enable / flag register fields
`define PIC_F1_TMRA 7
`define PIC_F1_WKP 5
// Second enable / flag register fields
`define PIC_F2_DXFER 7
`define PIC_F2_ADC 6
`define PIC_F2_TMRG 4
`define PIC_F2_TMRFH 3
`define PIC_F2_TMRFL 2
`define PIC_F2_TMRC 1
`define PIC_F2_ASYNC 0
// Writable flag bits (bit 5 of the first reads 1, bit 6 reads 0)
`define PIC_RF1_MASK 8'h9f
`define PIC_RF2_MASK 8'hdf

// Vector numbers
`define PIC_VEC_PIN0 5'd4
`define PIC_VEC_WKP 5'd9
`define PIC_VEC_TMRA 5'd11
`define PIC_VEC_ASYNC 5'd12
`define PIC_VEC_TMRC 5'd13
`define PIC_VEC_TMRFL 5'd14
`define PIC_VEC_TMRFH 5'd15
`define PIC_VEC_TMRG 5'd16
`define PIC_VEC_SER1 5'd17
`define PIC_VEC_SER2 5'd18
`define PIC_VEC_ADC 5'd19
`define PIC_VEC_DXFER 5'd20
`define PIC_VEC_LAST 20

// AXI responses
`define PIC_RESP_OKAY 2'b00
`define PIC_RESP_DECERR 2'b11

`endif

// ===== verilog/pic_ctrl.v
// Prioritized interrupt controller: pin edge capture, request flags,
// enables, fixed-priority vector selection, AXI4-Lite register slave.
// Assumes all inputs synchronous to sys_clk; peripheral events are
// one-cycle pulses, serial unit requests are levels gated inside the unit.
//
// Operation
// R1 - Only highest priority pending request presented
// R2 - Thirteen external and 23 internal request inputs; the code takes 14 internal request inputs
// R3 - Mask bit set: flags set, nothing accepted
// R4 - Each pin selects rising or falling edge
// R5 - Fixed priority, vectors 4-8, 9, to 20
// R6 - Timer C events share vector 13
// R7 - Low pair-timer events share vector 14
// R8 - High pair-timer events share vector 15
// R9 - Capture timer events share vector 16
// R10 - No vector in reserved address ranges
// R11 - Software writes only clear flags with 0
// R12 - Flag registers reset to 20, 00, 00
// R13 - Enable registers reset to 00
// R14 - Edge select bits 4-0 for pins 4-0
// R15 - Edge select bits 7-5 read 1
// R16 - Edge bit 0 falling, 1 rising
// R17 - Enable bit gates pin request into resolution
// R18 - All masked until first instruction after reset
// R19 - Accept only at instruction or exception end
// R20 - Output vector number; entry at twice it
// R21 - Present only if flag, enable, unmasked; the code presents serial unit requests (vectors 17, 18) with no flag or enable
// R22 - Flag sets on edge, holds until cleared
`timescale 1ns/10ps
`include "pic_regs.vh"

module pic_ctrl (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // External request pins
  input wire [4:0] irq_pin,
  input wire [7:0] wakeup_pin,
  // Peripheral event pulses and serial unit request levels
  input wire tmr_a_ovf,
  input wire async_ovf,
  input wire [1:0] tmr_c_evt,
  input wire [1:0] tmr_fl_evt,
  input wire [1:0] tmr_fh_evt,
  input wire [1:0] tmr_g_evt,
  input wire [1:0] serial_unit_req,
  input wire adc_end,
  input wire direct_xfer,
  // CPU exception sequencer
  input wire cpu_mask,
  input wire cpu_insn_end,
  output reg int_pending_reg,
  output reg int_accept_reg,
  output reg [4:0] vec_num_reg,
  output reg [15:0] vec_addr_reg,
  // AXI4-Lite write address and data
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Lowest vector number set in a pending map wins
  function [4:0] pic_first;
    input [20:0] pend;
    integer i;
    begin
      pic_first = 5'd0;
      for (i = `PIC_VEC_LAST; i >= 0; i = i - 1)
        if (pend[i])
          pic_first = i[4:0];
    end
  endfunction

  // Register index match against a 16-bit word index
  function pic_hit;
    input [17:0] addr;
    input [15:0] idx;
    begin
      pic_hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  reg [7:0] wedge_reg;
  reg [4:0] pedge_reg;
  reg [7:0] en1_reg;
  reg [7:0] en2_reg;
  reg [7:0] rf1_reg;
  reg [7:0] rf2_reg;
  reg [7:0] wrf_reg;
  reg [4:0] irq_prev_reg;
  reg [7:0] wkp_prev_reg;
  reg boot_hold_reg;
  reg [7:0] rf1_next;
  reg [7:0] rf2_next;
  reg [7:0] wrf_next;
  reg [20:0] pend;
  reg [31:0] rdata_next;
  reg rd_hit;
  reg wr_hit;

  wire [4:0] irq_edge;
  wire [7:0] wkp_edge;
  wire wr_go;
  wire rd_go;
  wire wr_lane;
  wire [7:0] wbyte;
  wire [4:0] win_vec;
  wire can_take;

  // Selected edge detection; pins are already synchronous
  assign irq_edge = (irq_pin & ~irq_prev_reg & pedge_reg)
    | (~irq_pin & irq_prev_reg & ~pedge_reg); // R4 R16
  assign wkp_edge = (wakeup_pin & ~wkp_prev_reg & wedge_reg)
    | (~wakeup_pin & wkp_prev_reg & ~wedge_reg); // R4 R16

  // Write taken only with address and data both present
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
    && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wr_lane = wr_go && s_axi_wstrb[0];
  assign wbyte = s_axi_wdata[7:0];

  // Flag update: hardware set wins over a same-cycle clear
  always @*
  begin
    rf1_next = rf1_reg;
    rf2_next = rf2_reg;
    wrf_next = wrf_reg;
    if (wr_lane && pic_hit(s_axi_awaddr, `PIC_IDX_RF1))
      rf1_next = rf1_reg & (wbyte | ~`PIC_RF1_MASK); // R11
    if (wr_lane && pic_hit(s_axi_awaddr, `PIC_IDX_RF2))
      rf2_next = rf2_reg & (wbyte | ~`PIC_RF2_MASK); // R11
    if (wr_lane && pic_hit(s_axi_awaddr, `PIC_IDX_WRF))
      wrf_next = wrf_reg & wbyte; // R11
    // Sources set flags regardless of the CPU mask
    rf1_next[4:0] = rf1_next[4:0] | irq_edge; // R22 R3 R2
    rf1_next[`PIC_F1_TMRA] = rf1_next[`PIC_F1_TMRA] | tmr_a_ovf;
    wrf_next = wrf_next | wkp_edge; // R22 R3
    rf2_next[`PIC_F2_ASYNC] = rf2_next[`PIC_F2_ASYNC] | async_ovf;
    rf2_next[`PIC_F2_TMRC] = rf2_next[`PIC_F2_TMRC] | (|tmr_c_evt); // R6
    rf2_next[`PIC_F2_TMRFL] = rf2_next[`PIC_F2_TMRFL] | (|tmr_fl_evt); // R7
    rf2_next[`PIC_F2_TMRFH] = rf2_next[`PIC_F2_TMRFH] | (|tmr_fh_evt); // R8
    rf2_next[`PIC_F2_TMRG] = rf2_next[`PIC_F2_TMRG] | (|tmr_g_evt); // R9
    rf2_next[`PIC_F2_ADC] = rf2_next[`PIC_F2_ADC] | adc_end;
    rf2_next[`PIC_F2_DXFER] = rf2_next[`PIC_F2_DXFER] | direct_xfer;
  end

  // Pending map in vector order; reserved vectors stay zero
  always @*
  begin
    pend = 21'h00_0000; // R10
    pend[8:4] = rf1_reg[4:0] & en1_reg[4:0]; // R5 R17 R21
    pend[`PIC_VEC_WKP] = (|wrf_reg) & en1_reg[`PIC_F1_WKP]; // R5
    pend[`PIC_VEC_TMRA] = rf1_reg[`PIC_F1_TMRA] & en1_reg[`PIC_F1_TMRA];
    pend[`PIC_VEC_ASYNC] = rf2_reg[`PIC_F2_ASYNC] & en2_reg[`PIC_F2_ASYNC];
    pend[`PIC_VEC_TMRC] = rf2_reg[`PIC_F2_TMRC] & en2_reg[`PIC_F2_TMRC]; // R6
    pend[`PIC_VEC_TMRFL] = rf2_reg[`PIC_F2_TMRFL] & en2_reg[`PIC_F2_TMRFL]; // R7
    pend[`PIC_VEC_TMRFH] = rf2_reg[`PIC_F2_TMRFH] & en2_reg[`PIC_F2_TMRFH]; // R8
    pend[`PIC_VEC_TMRG] = rf2_reg[`PIC_F2_TMRG] & en2_reg[`PIC_F2_TMRG]; // R9
    pend[`PIC_VEC_SER1] = serial_unit_req[0];
    pend[`PIC_VEC_SER2] = serial_unit_req[1];
    pend[`PIC_VEC_ADC] = rf2_reg[`PIC_F2_ADC] & en2_reg[`PIC_F2_ADC];
    pend[`PIC_VEC_DXFER] = rf2_reg[`PIC_F2_DXFER] & en2_reg[`PIC_F2_DXFER];
  end

  assign win_vec = pic_first(pend); // R1 R5
  assign can_take = (|pend) && !cpu_mask && !boot_hold_reg; // R3 R18 R21

  // Read mux and address decode
  always @*
  begin
    rdata_next = 32'h0000_0000;
    rd_hit = 1'b1;
    if (pic_hit(s_axi_araddr, `PIC_IDX_WEDGE))
      rdata_next[7:0] = wedge_reg;
    else if (pic_hit(s_axi_araddr, `PIC_IDX_PEDGE))
      rdata_next[7:0] = `PIC_PEDGE_FIXED | {3'b000, pedge_reg}; // R15
    else if (pic_hit(s_axi_araddr, `PIC_IDX_EN1))
      rdata_next[7:0] = en1_reg;
    else if (pic_hit(s_axi_araddr, `PIC_IDX_EN2))
      rdata_next[7:0] = en2_reg;
    else if (pic_hit(s_axi_araddr, `PIC_IDX_RF1))
      rdata_next[7:0] = rf1_reg;
    else if (pic_hit(s_axi_araddr, `PIC_IDX_RF2))
      rdata_next[7:0] = rf2_reg;
    else if (pic_hit(s_axi_araddr, `PIC_IDX_WRF))
      rdata_next[7:0] = wrf_reg;
    else
      rd_hit = 1'b0;
  end

  always @*
  begin
    wr_hit = pic_hit(s_axi_awaddr, `PIC_IDX_WEDGE)
      || pic_hit(s_axi_awaddr, `PIC_IDX_PEDGE)
      || pic_hit(s_axi_awaddr, `PIC_IDX_EN1)
      || pic_hit(s_axi_awaddr, `PIC_IDX_EN2)
      || pic_hit(s_axi_awaddr, `PIC_IDX_RF1)
      || pic_hit(s_axi_awaddr, `PIC_IDX_RF2)
      || pic_hit(s_axi_awaddr, `PIC_IDX_WRF);
  end

  // Configuration registers
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wedge_reg <= `PIC_RST_WEDGE;
      pedge_reg <= 5'b00000; // R16
      en1_reg <= `PIC_RST_EN; // R13
      en2_reg <= `PIC_RST_EN; // R13
    end
    else if (wr_lane)
    begin
      if (pic_hit(s_axi_awaddr, `PIC_IDX_WEDGE))
        wedge_reg <= wbyte;
      if (pic_hit(s_axi_awaddr, `PIC_IDX_PEDGE))
        pedge_reg <= wbyte[4:0]; // R14 R15
      if (pic_hit(s_axi_awaddr, `PIC_IDX_EN1))
        en1_reg <= wbyte;
      if (pic_hit(s_axi_awaddr, `PIC_IDX_EN2))
        en2_reg <= wbyte;
    end
  end

  // Flags and edge history
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rf1_reg <= `PIC_RST_RF1; // R12
      rf2_reg <= `PIC_RST_RF2; // R12
      wrf_reg <= `PIC_RST_WRF; // R12
      irq_prev_reg <= 5'b00000;
      wkp_prev_reg <= 8'h00;
    end
    else
    begin
      rf1_reg <= rf1_next;
      rf2_reg <= rf2_next;
      wrf_reg <= wrf_next;
      irq_prev_reg <= irq_pin;
      wkp_prev_reg <= wakeup_pin;
    end
  end

  // CPU side; the first instruction end lifts the boot hold
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      boot_hold_reg <= 1'b1; // R18
      int_pending_reg <= 1'b0;
      int_accept_reg <= 1'b0;
      vec_num_reg <= 5'd0;
      vec_addr_reg <= 16'h0000;
    end
    else
    begin
      if (cpu_insn_end)
        boot_hold_reg <= 1'b0; // R18
      int_pending_reg <= can_take; // R21
      // Vector stays frozen from accept until the next accept
      int_accept_reg <= can_take && cpu_insn_end; // R19
      if (can_take && cpu_insn_end)
      begin
        vec_num_reg <= win_vec; // R20
        vec_addr_reg <= {10'h000, win_vec, 1'b0}; // R20 R10
      end
    end
  end

  // AXI4-Lite handshakes, one transfer of each kind at a time
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PIC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PIC_RESP_OKAY : `PIC_RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rd_hit ? `PIC_RESP_OKAY : `PIC_RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pic_ctrl

// ===== test/pic_ctrl_chk.sv
// Port checker for the interrupt controller.
// Assumes it is bound onto pic_ctrl, one clock domain.
`timescale 1ns/10ps
module pic_ctrl_chk (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // CPU side
  input wire cpu_mask,
  input wire cpu_insn_end,
  input wire int_pending_reg,
  input wire int_accept_reg,
  input wire [4:0] vec_num_reg,
  input wire [15:0] vec_addr_reg,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  reg hold_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Boot hold as the CPU sees it
  always @(posedge sys_clk)
    hold_reg <= sys_rst ? 1'b1 : (hold_reg && !cpu_insn_end);
  sequence s_wreq;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  endsequence
  sequence s_wans;
    s_axi_bvalid && s_axi_awready && s_axi_wready;
  endsequence
  a_addr_twice: assert property (vec_addr_reg == {10'h000, vec_num_reg, 1'b0})
    else $error("vector address not twice number");
  a_mask_blocks: assert property (cpu_mask |=> !int_pending_reg)
    else $error("pending while masked");
  a_accept_cause: assert property (int_accept_reg |-> $past(cpu_insn_end) && !$past(cpu_mask))
    else $error("accept without boundary");
  a_vec_legal: assert property (int_accept_reg |-> vec_num_reg inside {[4:9], [11:20]})
    else $error("illegal vector");
  a_vec_holds: assert property (!int_accept_reg |=> $stable(vec_num_reg) || int_accept_reg)
    else $error("vector moved without accept");
  a_boot_hold: assert property (hold_reg |=> !int_pending_reg && !int_accept_reg)
    else $error("request before first boundary");
  a_pend_unmask: assert property ($rose(int_pending_reg) |-> !$past(cpu_mask))
    else $error("pending rose while masked");
  a_write_resp: assert property (s_wreq |=> s_wans)
    else $error("write not answered");
  a_read_resp: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
endmodule // pic_ctrl_chk

// ===== test/pic_cpu_model.sv
// Stand-in for the CPU exception sequencer.
// Assumes the controller's clock and reset; gap sets the instruction length.
`timescale 1ns/10ps
module pic_cpu_model (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Control
  input wire run,
  input wire [3:0] gap,
  // Controller side
  input wire int_accept_reg,
  output reg cpu_insn_end,
  output reg [7:0] n_taken
);
  reg [3:0] cnt_reg;
  always @(posedge sys_clk)
  begin
    cnt_reg <= (sys_rst || cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
    cpu_insn_end <= !sys_rst && run && cnt_reg == 4'h0;
    n_taken <= sys_rst ? 8'h00 : n_taken + {7'h00, int_accept_reg};
  end
endmodule // pic_cpu_model

// ===== test/test_prioritized_interrupt_controller.sv
// Self-checking bench for the interrupt controller.
// Assumes pic_ctrl, the CPU stand-in and the port checker.
`timescale 1ns/10ps
module test_prioritized_interrupt_controller;
  logic sys_clk = 0, sys_rst = 1, cpu_mask = 1, cpu_insn_end, run = 0;
  logic tmr_a_ovf = 0, async_ovf = 0, adc_end = 0, direct_xfer = 0;
  logic [1:0] serial_unit_req = 0, tmr_c_evt = 0, tmr_fl_evt = 0, tmr_fh_evt = 0;
  logic [1:0] tmr_g_evt = 0, s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] irq_pin = 0, vec_num_reg;
  logic [7:0] wakeup_pin = 8'hff, e;
  logic int_pending_reg, int_accept_reg, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 0, gap = 4'h3;
  logic [15:0] vec_addr_reg;
  logic [15:0] rix[8] = '{16'hff90, 16'hfff2, 16'hfff3, 16'hfff4, 16'hfff6, 16'hfff7,
    16'hfff9, 16'hfff5};
  logic [7:0] rrv[8] = '{8'h00, 8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  int n_fail = 0, comparisons = 0, vq[$];

  pic_ctrl i_dut (.*);
  pic_cpu_model i_cpu (.sys_clk, .sys_rst, .run, .gap, .int_accept_reg, .cpu_insn_end,
    .n_taken());

  always #50 sys_clk = ~sys_clk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait for a level sampled at the rising edge
  // Selector: 0 write response, 1 read response, 2 accept pulse
  task automatic wt(int sel);
    int k;
    logic s;
    k = 0;
    s = 1'b0;
    do
    begin
      @(posedge sys_clk);
      k++;
      s = sel == 0 ? s_axi_bvalid : sel == 1 ? s_axi_rvalid : int_accept_reg;
    end
    while (s !== 1'b1 && k < 200);
    if (s !== 1'b1)
    begin
      n_fail++;
      complete_run;
    end
  endtask

  // One bus cycle; ready rises together with the response valid
  task automatic bus(bit w, logic [15:0] i, logic [7:0] d);
    if (w)
    begin
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      wt(0);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      s_axi_bready <= 0;
    end
    else
    begin
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      wt(1);
      s_axi_arvalid <= 0;
      s_axi_rready <= 0;
    end
    rsp = w ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    // Idle edge so a following call never re-raises valid in the same step
    @(posedge sys_clk);
  endtask

  initial
  begin
    e = $urandom(32'h4e73_ef79);
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int j = 0; j < 8; j++)
    begin
      bus(0, rix[j], 8'h00);
      chk("reset value", q, {24'h00_0000, rrv[j]});
      chk("response", rsp, j == 7 ? 2'b11 : 2'b00);
    end
    e = $urandom;
    bus(1, 16'hfff2, e);
    bus(0, 16'hfff2, 8'h00);
    chk("edge select", q, {24'h00_0000, e | 8'he0});
    bus(1, 16'hfff3, 8'h3f);
    // Park each pin on the level opposite to its chosen edge
    irq_pin <= ~e[4:0];
    repeat (2) @(posedge sys_clk);
    bus(1, 16'hfff6, 8'h00);
    irq_pin <= e[4:0];
    wakeup_pin <= ~(8'h01 << e[7:5]);
    repeat (2) @(posedge sys_clk);
    bus(1, 16'hfff6, 8'hff);
    bus(0, 16'hfff6, 8'h00);
    chk("pin flags", q, 32'h0000_003f);
    bus(0, 16'hfff9, 8'h00);
    chk("wake flags", q, {24'h00_0000, 8'h01 << e[7:5]});
    chk("masked pending", int_pending_reg, 1'b0);
    vq = '{4, 5, 6, 7, 8, 9};
    cpu_mask <= 0;
    for (int p = 0; p < 6; p++)
    begin
      gap <= 4'($urandom_range(0, 7));
      run <= 1;
      wt(2);
      run <= 0;
      chk("vector", vec_num_reg, vq[0]);
      chk("vector address", vec_addr_reg, 2 * vq.pop_front());
      bus(1, p < 5 ? 16'hfff6 : 16'hfff9, p < 5 ? ~(8'h01 << p) : 8'h00);
      repeat (3) @(posedge sys_clk);
    end
    bus(1, 16'hfff4, 8'h1e);
    for (int j = 0; j < 8; j++)
    begin
      cpu_mask <= 1;
      {tmr_g_evt, tmr_fh_evt, tmr_fl_evt, tmr_c_evt} <= 8'h01 << j;
      @(posedge sys_clk);
      {tmr_g_evt, tmr_fh_evt, tmr_fl_evt, tmr_c_evt} <= 8'h00;
      run <= 1;
      repeat (12) @(posedge sys_clk);
      chk("masked pending", int_pending_reg, 1'b0);
      bus(0, 16'hfff7, 8'h00);
      chk("timer flags", q, 32'h0000_0002 << (j / 2));
      cpu_mask <= 0;
      wt(2);
      run <= 0;
      chk("shared vector", vec_num_reg, 13 + j / 2);
      chk("shared address", vec_addr_reg, 26 + 2 * (j / 2));
      bus(1, 16'hfff7, 8'h00);
      repeat (3) @(posedge sys_clk);
    end
    // Every remaining peripheral at once, then released in priority order
    bus(1, 16'hfff3, 8'h80);
    bus(1, 16'hfff4, 8'hdf);
    cpu_mask <= 1;
    tmr_a_ovf <= 1;
    async_ovf <= 1;
    adc_end <= 1;
    direct_xfer <= 1;
    serial_unit_req <= 2'b11;
    {tmr_g_evt, tmr_fh_evt, tmr_fl_evt, tmr_c_evt} <= {2'($urandom_range(1, 3)),
      2'($urandom_range(1, 3)), 2'($urandom_range(1, 3)), 2'($urandom_range(1, 3))};
    @(posedge sys_clk);
    tmr_a_ovf <= 0;
    async_ovf <= 0;
    adc_end <= 0;
    direct_xfer <= 0;
    {tmr_g_evt, tmr_fh_evt, tmr_fl_evt, tmr_c_evt} <= 8'h00;
    bus(0, 16'hfff6, 8'h00);
    chk("peripheral flags first", q, 32'h0000_00a0);
    bus(0, 16'hfff7, 8'h00);
    chk("peripheral flags second", q, 32'h0000_00df);
    vq = '{11, 12, 13, 14, 15, 16, 17, 18, 19, 20};
    cpu_mask <= 0;
    while (vq.size() > 0)
    begin
      run <= 1;
      wt(2);
      run <= 0;
      chk("pending", int_pending_reg, 1'b1);
      chk("peripheral vector", vec_num_reg, vq[0]);
      chk("peripheral address", vec_addr_reg, 2 * vq[0]);
      if (vq[0] == 11)
        bus(1, 16'hfff6, 8'h7f);
      else if (vq[0] == 17 || vq[0] == 18)
        serial_unit_req[vq[0] - 17] <= 1'b0;
      else
        bus(1, 16'hfff7, vq[0] < 19 ? ~(8'h01 << (vq[0] - 12)) : ~(8'h40 << (vq[0] - 19)));
      vq.delete(0);
      repeat (3) @(posedge sys_clk);
    end
    complete_run;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end
endmodule // test_prioritized_interrupt_controller

bind pic_ctrl pic_ctrl_chk u_chk (.*);
